//--- ascp_pkg.sv
// Purpose: shared constants and types for the converter serial port
// Assumes: clk_sys at 50 MHz; pins are asynchronous to clk_sys
// Notes: config stream layout is prefix(3) address(5) speed(5), msb first
package ascp_pkg;

   localparam int CLK_PERIOD_NS = 20;
   // internally made serial clock: 160 ns period
   localparam int SCK_HALF_NS = 80;
   localparam int SCK_HALF_CYC =
      (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] DIV_LAST = 2'(SCK_HALF_CYC - 1);

   localparam logic [5:0] FRAME_BITS = 6'h20;
   localparam logic [5:0] FRAME_LAST = 6'h1f;
   localparam logic [3:0] CFG_BITS = 4'hd;

   localparam logic [2:0] PFX_UPDATE = 3'h5;
   localparam logic [2:0] PFX_KEEP_A = 3'h0;
   localparam logic [2:0] PFX_KEEP_B = 3'h4;

   // positions inside the 13-bit captured stream
   localparam int CIN_PFX_HI = 12;
   localparam int CIN_PFX_LO = 10;
   localparam int CIN_SGL = 9;
   localparam int CIN_ODD = 8;
   localparam int CIN_GLOBAL_REFERENCE_SELECT = 7;
   localparam int CIN_PAIR_HI = 6;
   localparam int CIN_PAIR_LO = 5;
   localparam int CIN_SPD_HI = 4;
   localparam int CIN_SPD_LO = 0;

   // speed code is osr[3:0] then the 2x bit; 5'h06 is osr 256, 1x
   localparam logic [4:0] SPEED_KEEP = 5'h00;
   localparam logic [4:0] SPEED_RESET = 5'h06;

   typedef enum logic [2:0] {
      ST_CONVERT = 3'b001,
      ST_SLEEP = 3'b010,
      ST_DATAOUT = 3'b100
   } ascp_fsm_type;

   typedef struct packed {
      logic cs_n;
      logic sck;
      logic sdi;
      logic clock_source_strap;
   } ascp_pin_type;

   localparam ascp_pin_type PIN_RESET = '{cs_n: 1'b1, sck: 1'b0,
      sdi: 1'b0, clock_source_strap: 1'b0};

   typedef struct packed {
      logic single_ended_select;
      logic polarity_odd;
      logic global_reference_select;
      logic pair_index_high;
      logic pair_index_low;
      logic [4:0] speed_code;
   } ascp_cfg_type;

   typedef struct packed {
      logic [2:0] pos_channel;
      logic [2:0] neg_channel;
      logic common_negative_input;
      logic global_reference_select;
      logic [1:0] ref_pair;
      logic [4:0] speed_code;
   } ascp_mux_type;

   typedef struct packed {
      logic sck_out;
      logic sck_oe;
      logic sdo_out;
      logic sdo_oe;
   } ascp_pad_type;

   typedef struct packed {
      ascp_fsm_type fsm;
      logic [31:0] dout;
      logic [12:0] cin;
      logic [3:0] nrise;
      logic [5:0] nfall;
      logic sck_prev;
      logic cs_prev;
      logic [1:0] div;
      logic sck_gen;
      logic sdo;
      logic sdo_oe;
      logic start;
      ascp_cfg_type cfg;
      ascp_mux_type mux;
   } ascp_state_type;

   localparam ascp_cfg_type CFG_RESET = '{single_ended_select: 1'b0,
      polarity_odd: 1'b0, global_reference_select: 1'b0,
      pair_index_high: 1'b0, pair_index_low: 1'b0,
      speed_code: SPEED_RESET};

   localparam ascp_mux_type MUX_RESET = '{pos_channel: 3'h0,
      neg_channel: 3'h1, common_negative_input: 1'b0,
      global_reference_select: 1'b0, ref_pair: 2'h0,
      speed_code: SPEED_RESET};

endpackage : ascp_pkg

//--- ascp_sync.sv
// Purpose: two-flop synchroniser for the serial port pins
// Assumes: inputs may change at any time relative to clk_sys
// Notes: the first stage feeds only the second stage
`timescale 1ns/10ps
module ascp_sync (
   input wire logic clk_sys,
   input wire logic rst,
   input ascp_pkg::ascp_pin_type pin_async,
   output ascp_pkg::ascp_pin_type pin_sync
);
   import ascp_pkg::*;

   typedef struct packed {
      ascp_pin_type meta;
      ascp_pin_type q;
   } ascp_sync_type;

   ascp_sync_type sy_r;
   ascp_sync_type sy_nxt;

   always_comb begin
      sy_nxt.meta = pin_async;
      sy_nxt.q = sy_r.meta;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sy_r <= '{meta: PIN_RESET, q: PIN_RESET};
      end else begin
         sy_r <= sy_nxt;
      end
   end

   assign pin_sync = sy_r.q;

endmodule : ascp_sync

//--- ascp_port.sv
// Purpose: serial status/result/config port of a multi-channel converter
// Assumes: converter core on clk_sys; conv_done pulses once per conversion
// Notes: the serial clock is sampled, never used as a clock
`timescale 1ns/10ps
module ascp_port (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic sck_in,
   input wire logic sdi,
   input wire logic clock_source_strap,
   input wire logic conv_done,
   input wire logic [31:0] conv_result,
   output logic conv_start,
   output ascp_pkg::ascp_mux_type mux_sel,
   output ascp_pkg::ascp_pad_type pad
);
   import ascp_pkg::*;

   localparam ascp_state_type ST_RESET = '{fsm: ST_CONVERT,
      dout: 32'h0000_0000, cin: 13'h0000, nrise: 4'h0, nfall: 6'h00,
      sck_prev: 1'b0, cs_prev: 1'b1, div: 2'h0, sck_gen: 1'b0,
      sdo: 1'b1, sdo_oe: 1'b0, start: 1'b1, cfg: CFG_RESET,
      mux: MUX_RESET};

   ascp_pin_type pin_raw;
   ascp_pin_type pin_s;
   ascp_state_type st_r;
   ascp_state_type st_nxt;

   logic sck_now;
   logic cs_low;
   logic rise;
   logic fall;
   logic cs_rise;
   logic apply_now;

   // merges a finished config stream into the held setting
   function automatic ascp_cfg_type f_apply(input ascp_cfg_type cur,
                                            input logic [12:0] cin);
      ascp_cfg_type nc;
      nc = cur;
      // other prefixes than 101 leave the setting alone
      if (cin[CIN_PFX_HI:CIN_PFX_LO] == PFX_UPDATE) begin
         nc.single_ended_select = cin[CIN_SGL];
         nc.polarity_odd = cin[CIN_ODD];
         nc.global_reference_select = cin[CIN_GLOBAL_REFERENCE_SELECT];
         nc.pair_index_high = cin[CIN_PAIR_HI];
         nc.pair_index_low = cin[CIN_PAIR_LO];
         if (cin[CIN_SPD_HI:CIN_SPD_LO] != SPEED_KEEP) begin
            nc.speed_code = cin[CIN_SPD_HI:CIN_SPD_LO];
         end
      end
      return nc;
   endfunction : f_apply

   // turns the held setting into multiplexer and reference selects
   function automatic ascp_mux_type f_mux(input ascp_cfg_type c);
      ascp_mux_type m;
      logic [1:0] pair;
      pair = {c.pair_index_high, c.pair_index_low};
      m.pos_channel = {pair, c.polarity_odd};
      m.neg_channel = {pair, ~c.polarity_odd};
      m.common_negative_input = c.single_ended_select;
      m.global_reference_select = c.global_reference_select;
      m.ref_pair = pair;
      m.speed_code = c.speed_code;
      return m;
   endfunction : f_mux

   assign pin_raw = '{cs_n: cs_n, sck: sck_in, sdi: sdi,
      clock_source_strap: clock_source_strap};

   ascp_sync u_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .pin_async(pin_raw),
      .pin_sync(pin_s)
   );

   always_comb begin
      st_nxt = st_r;
      st_nxt.start = 1'b0;
      apply_now = 1'b0;
      // in internal mode our own divider is the serial clock
      sck_now = pin_s.clock_source_strap ? st_r.sck_gen : pin_s.sck;
      cs_low = !pin_s.cs_n;
      rise = cs_low && sck_now && !st_r.sck_prev;
      fall = cs_low && !sck_now && st_r.sck_prev;
      cs_rise = pin_s.cs_n && !st_r.cs_prev;
      st_nxt.sck_prev = sck_now;
      st_nxt.cs_prev = pin_s.cs_n;

      // clock generator runs only when a host could be listening
      if (pin_s.clock_source_strap && cs_low &&
          st_r.fsm != ST_CONVERT) begin
         if (st_r.div == DIV_LAST) begin
            st_nxt.div = 2'h0;
            st_nxt.sck_gen = ~st_r.sck_gen;
         end else begin
            st_nxt.div = st_r.div + 2'h1;
         end
      end else begin
         st_nxt.div = 2'h0;
         st_nxt.sck_gen = 1'b0;
      end

      unique case (st_r.fsm)
         ST_CONVERT: begin
            if (conv_done) begin
               // first bit is the cleared pending flag
               st_nxt.dout = {1'b0, conv_result[30:0]};
               st_nxt.fsm = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (rise) begin
               st_nxt.fsm = ST_DATAOUT;
               st_nxt.cin = {12'h000, pin_s.sdi};
               st_nxt.nrise = 4'h1;
               st_nxt.nfall = 6'h00;
            end
         end
         ST_DATAOUT: begin
            if (cs_rise) begin
               // a partial stream is applied only if it is complete
               apply_now = (st_r.nrise == CFG_BITS);
               st_nxt.start = 1'b1;
               st_nxt.fsm = ST_CONVERT;
            end else begin
               if (rise && st_r.nrise != CFG_BITS) begin
                  st_nxt.cin = {st_r.cin[11:0], pin_s.sdi};
                  st_nxt.nrise = st_r.nrise + 4'h1;
               end
               if (fall) begin
                  st_nxt.dout = {st_r.dout[30:0], 1'b1};
                  st_nxt.nfall = st_r.nfall + 6'h01;
                  if (st_r.nfall == FRAME_LAST) begin
                     apply_now = (st_r.nrise == CFG_BITS);
                     st_nxt.start = 1'b1;
                     st_nxt.fsm = ST_CONVERT;
                  end
               end
            end
         end
      endcase

      if (apply_now) begin
         st_nxt.cfg = f_apply(st_r.cfg, st_r.cin);
      end
      st_nxt.mux = f_mux(st_nxt.cfg);

      // convert shows the pending flag high, sleep shows it low
      unique case (st_nxt.fsm)
         ST_CONVERT: st_nxt.sdo = 1'b1;
         ST_SLEEP: st_nxt.sdo = 1'b0;
         ST_DATAOUT: st_nxt.sdo = st_nxt.dout[31];
      endcase
      st_nxt.sdo_oe = !pin_s.cs_n;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_r <= ST_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign conv_start = st_r.start;
   assign mux_sel = st_r.mux;
   assign pad.sck_out = st_r.sck_gen;
   assign pad.sck_oe = pin_s.clock_source_strap;
   assign pad.sdo_out = st_r.sdo;
   assign pad.sdo_oe = st_r.sdo_oe;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   a_sdo_tristate: assert property (
      pin_s.cs_n |=> !pad.sdo_oe)
      else $error("data output driven while deselected");

   a_sdo_enable: assert property (
      !pin_s.cs_n |=> pad.sdo_oe)
      else $error("data output not driven while selected");

   a_pending_high: assert property (
      (st_r.fsm == ST_CONVERT) |-> pad.sdo_out)
      else $error("pending flag low during conversion");

   a_pending_low: assert property (
      (st_r.fsm == ST_SLEEP) |-> !pad.sdo_out)
      else $error("pending flag high during sleep");

   a_done_sleep: assert property (
      (st_r.fsm == ST_CONVERT) && conv_done |=> st_r.fsm == ST_SLEEP)
      else $error("finished conversion did not enter sleep");

   a_load_result: assert property (
      (st_r.fsm == ST_CONVERT) && conv_done
      |=> st_r.dout == {1'b0, $past(conv_result[30:0])})
      else $error("result word not loaded for output");

   a_sleep_hold: assert property (
      (st_r.fsm == ST_SLEEP) && !rise |=> st_r.fsm == ST_SLEEP)
      else $error("sleep left without a rising clock");

   a_sleep_exit: assert property (
      (st_r.fsm == ST_SLEEP) && rise |=> st_r.fsm == ST_DATAOUT)
      else $error("rising clock did not leave sleep");

   a_first_capture: assert property (
      (st_r.fsm == ST_SLEEP) && rise
      |=> (st_r.nrise == 4'h1) && (st_r.cin[0] == $past(pin_s.sdi)))
      else $error("first stream bit not captured");

   a_bit_capture: assert property (
      (st_r.fsm == ST_DATAOUT) && rise && (st_r.nrise != CFG_BITS)
      |=> st_r.cin[0] == $past(pin_s.sdi))
      else $error("stream bit not captured on rising clock");

   a_rise_limit: assert property (
      (st_r.fsm == ST_DATAOUT) && rise && (st_r.nrise == CFG_BITS)
      |=> $stable(st_r.cin))
      else $error("stream bit taken beyond the thirteenth");

   a_cs_abort: assert property (
      (st_r.fsm == ST_DATAOUT) && cs_rise
      |=> (st_r.fsm == ST_CONVERT) && conv_start ##1 !conv_start)
      else $error("select release did not restart conversion");

   a_abort_keep: assert property (
      (st_r.fsm == ST_DATAOUT) && cs_rise && (st_r.nrise != CFG_BITS)
      |=> st_r.cfg == $past(st_r.cfg))
      else $error("partial stream changed the setting");

   a_start_pulse: assert property (
      conv_start |=> !conv_start)
      else $error("conversion start longer than one cycle");

   a_dataout_sdo: assert property (
      (st_r.fsm == ST_DATAOUT) |-> pad.sdo_out == st_r.dout[31])
      else $error("output bit not the head of the result word");

   a_bit_shift: assert property (
      (st_r.fsm == ST_DATAOUT) && fall && st_r.nfall != FRAME_LAST
      |=> pad.sdo_out == $past(st_r.dout[30]))
      else $error("wrong bit after falling clock");

   a_frame_end: assert property (
      (st_r.fsm == ST_DATAOUT) && fall && st_r.nfall == FRAME_LAST
      |=> (st_r.fsm == ST_CONVERT) && pad.sdo_out && conv_start)
      else $error("frame did not end after 32 falls");

   a_frame_count: assert property (
      (st_r.fsm == ST_DATAOUT) |-> st_r.nfall < FRAME_BITS)
      else $error("frame longer than 32 bits");

   // select high must freeze both shift registers, not just gate edges
   a_sck_ignored: assert property (
      pin_s.cs_n && (st_r.fsm != ST_CONVERT)
      |=> $stable(st_r.dout) && $stable(st_r.cin))
      else $error("clock edge taken while deselected");

   a_keep_prefix: assert property (
      apply_now && st_r.cin[CIN_PFX_HI:CIN_PFX_LO] != PFX_UPDATE
      |=> st_r.cfg == $past(st_r.cfg))
      else $error("setting changed without update prefix");

   a_apply_addr: assert property (
      apply_now && (st_r.cin[CIN_PFX_HI:CIN_PFX_LO] == PFX_UPDATE)
      |=> st_r.cfg.single_ended_select == $past(st_r.cin[CIN_SGL]) &&
      st_r.cfg.polarity_odd == $past(st_r.cin[CIN_ODD]) &&
      st_r.cfg.global_reference_select == $past(st_r.cin[CIN_GLOBAL_REFERENCE_SELECT]) &&
      {st_r.cfg.pair_index_high, st_r.cfg.pair_index_low} ==
      $past(st_r.cin[CIN_PAIR_HI:CIN_PAIR_LO]))
      else $error("update address not applied");

   a_apply_speed: assert property (
      apply_now && (st_r.cin[CIN_PFX_HI:CIN_PFX_LO] == PFX_UPDATE) &&
      (st_r.cin[CIN_SPD_HI:CIN_SPD_LO] != SPEED_KEEP)
      |=> st_r.cfg.speed_code == $past(st_r.cin[CIN_SPD_HI:CIN_SPD_LO]))
      else $error("update speed not applied");

   a_keep_speed: assert property (
      apply_now && st_r.cin[CIN_PFX_HI:CIN_PFX_LO] == PFX_UPDATE &&
      st_r.cin[CIN_SPD_HI:CIN_SPD_LO] == SPEED_KEEP
      |=> st_r.cfg.speed_code == $past(st_r.cfg.speed_code))
      else $error("speed changed by zero speed code");

   a_mux_follow: assert property (
      mux_sel.common_negative_input == st_r.cfg.single_ended_select &&
      mux_sel.pos_channel[0] == st_r.cfg.polarity_odd)
      else $error("multiplexer select out of step");

   a_neg_pair: assert property (
      !mux_sel.common_negative_input
      |-> mux_sel.neg_channel == (mux_sel.pos_channel ^ 3'h1))
      else $error("differential inputs not an adjacent pair");

   a_ref_pair: assert property (
      (mux_sel.ref_pair == mux_sel.pos_channel[2:1]) &&
      (mux_sel.global_reference_select ==
      st_r.cfg.global_reference_select))
      else $error("reference pair does not follow the channel pair");

   a_clock_drive: assert property (
      !pin_s.clock_source_strap |=> !pad.sck_out)
      else $error("serial clock driven in external mode");

   a_gen_idle: assert property (
      (st_r.fsm == ST_CONVERT) |=> !pad.sck_out)
      else $error("internal clock running during conversion");

   c_full_frame: cover property (
      (st_r.fsm == ST_DATAOUT) && fall && st_r.nfall == FRAME_LAST);
   c_abort: cover property ((st_r.fsm == ST_DATAOUT) && cs_rise);
   c_update: cover property (
      apply_now && st_r.cin[CIN_PFX_HI:CIN_PFX_LO] == PFX_UPDATE);
   c_internal_clk: cover property (
      pin_s.clock_source_strap && (st_r.fsm == ST_DATAOUT));
   c_keep_prefix: cover property (
      apply_now && st_r.cin[CIN_PFX_HI:CIN_PFX_LO] != PFX_UPDATE);

endmodule : ascp_port

//--- ascp_host.sv
// Purpose: host model on the far side of the converter serial port
// Assumes: external sck of 160 ns period, made inside frames and also by spin with select high
// Notes: sdo is read half a clk_sys after each rising sck
`timescale 1ns/10ps
module ascp_host (
   input wire logic clk_sys,
   input wire logic sdo,
   output logic cs_n,
   output logic sck,
   output logic sdi
);
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      sdi = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : tick
   task automatic sel(input logic v);
      cs_n <= v;
      sdi <= 1'b0;
   endtask : sel
   // sck toggles with select high; a correct device must not count them
   task automatic spin(input int n);
      for (int i = 0; i < n; i++) begin
         sck <= 1'b1;
         tick(4);
         sck <= 1'b0;
         tick(4);
      end
   endtask : spin
   // fewer than 32 clocks makes the frame end early by raising select
   task automatic frame(input logic [12:0] s, input int nclk,
         output logic [31:0] rd, output logic tail);
      rd = 32'h0;
      cs_n <= 1'b0;
      tick(6);
      for (int i = 0; i < nclk; i++) begin
         sdi <= (i < 13) ? s[12 - i] : 1'b0;
         tick(4);
         sck <= 1'b1;
         @(negedge clk_sys);
         rd = {rd[30:0], sdo};
         tick(4);
         sck <= 1'b0;
      end
      tick(6);
      tail = sdo;
      cs_n <= 1'b1;
      tick(8);
      // released data line must not keep showing the last bit
      sdi <= ~sdi;
   endtask : frame
endmodule : ascp_host

//--- ascp_port_tb_top.sv
// Purpose: self-checking bench for the converter serial port
// Assumes: conversions take 20 clk_sys in the stand-in core
// Notes: sdo floats to z when released, so a stray read fails
`timescale 1ns/10ps
module ascp_port_tb_top;
   import ascp_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic strap = 1'b0;
   logic conv_done = 1'b0;
   logic [31:0] conv_result = 32'hd5a3_c96b;
   logic [31:0] last = 32'h0;
   logic conv_start, cs_n, sck_h, sdi, sck_w, sdo_w;
   ascp_mux_type mux_sel, exp;
   ascp_pad_type pad;
   int mismatches = 0;
   int checks = 0;
   int cd = 0;
   int starts = 0;
   logic busy = 1'b1;
   logic [12:0] tbl [8] = '{13'h1402, 13'h1520, 13'h14d1, 13'h1669,
      13'h1786, 13'h03ff, 13'h12aa, 13'h15e3};
   assign sck_w = pad.sck_oe ? pad.sck_out : sck_h;
   assign sdo_w = pad.sdo_oe ? pad.sdo_out : 1'bz;
   always #10 clk_sys = ~clk_sys;
   ascp_port dut_u (
      .clk_sys(clk_sys),
      .rst(rst),
      .cs_n(cs_n),
      .sck_in(sck_w),
      .sdi(sdi),
      .clock_source_strap(strap),
      .conv_done(conv_done),
      .conv_result(conv_result),
      .conv_start(conv_start),
      .mux_sel(mux_sel),
      .pad(pad)
   );
   ascp_host host_u (
      .clk_sys(clk_sys),
      .sdo(sdo_w),
      .cs_n(cs_n),
      .sck(sck_h),
      .sdi(sdi)
   );
   // stand-in converter core: fixed 20-cycle conversion, new word each time
   always @(posedge clk_sys) begin
      conv_done <= 1'b0;
      if (conv_start === 1'b1) begin
         cd <= 20;
         busy <= 1'b1;
         starts <= starts + 1;
      end else if (cd == 1) begin
         conv_done <= 1'b1;
         busy <= 1'b0;
         cd <= 0;
         last <= conv_result;
      end else if (cd > 1) begin
         cd <= cd - 1;
      end
      if (conv_done)
         conv_result <= conv_result + 32'h1357_9bdf;
   end
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   task automatic chk(input string n, input logic [31:0] e,
         input logic [31:0] g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic chk_mux;
      ascp_mux_type got;
      got = mux_sel;
      // negative channel has no meaning once the common pin is chosen
      if (got.common_negative_input === 1'b1)
         got.neg_channel = 3'h0;
      chk("mux_sel", 32'(exp), 32'(got));
   endtask : chk_mux
   task automatic wait_ready;
      for (int i = 0; i < 200 && busy; i++)
         @(posedge clk_sys);
      if (busy) begin
         mismatches++;
         test_done;
      end
   endtask : wait_ready
   task automatic t_pending;
      host_u.sel(1'b0);
      host_u.tick(6);
      chk("pending busy", 32'h1, 32'(sdo_w));
      wait_ready;
      host_u.tick(6);
      chk("pending done", 32'h0, 32'(sdo_w));
      host_u.sel(1'b1);
      host_u.tick(6);
      chk("sdo_oe idle", 32'h0, 32'(pad.sdo_oe));
   endtask : t_pending
   task automatic t_frame(input logic [12:0] s, input int nclk);
      logic [31:0] rd;
      logic tail;
      int s0;
      wait_ready;
      s0 = starts;
      host_u.frame(s, nclk, rd, tail);
      if (nclk == 32) begin
         chk("frame", {1'b0, last[30:0]}, rd);
         chk("tail", 32'h1, 32'(tail));
         if (s[12:10] == PFX_UPDATE) begin
            exp.pos_channel = {s[6:5], s[8]};
            exp.neg_channel = s[9] ? 3'h0 : {s[6:5], ~s[8]};
            exp.common_negative_input = s[9];
            exp.global_reference_select = s[7];
            exp.ref_pair = s[6:5];
            if (s[4:0] != SPEED_KEEP)
               exp.speed_code = s[4:0];
         end
      end
      chk("starts", 32'(s0 + 1), 32'(starts));
      chk("sdo_oe off", 32'h0, 32'(pad.sdo_oe));
      chk_mux;
   endtask : t_frame
   task automatic t_internal;
      int n;
      int s0;
      logic prev;
      strap <= 1'b1;
      host_u.tick(4);
      wait_ready;
      chk("sck_oe", 32'h1, 32'(pad.sck_oe));
      s0 = starts;
      n = 0;
      prev = 1'b0;
      host_u.sel(1'b0);
      for (int i = 0; i < 600 && starts == s0; i++) begin
         @(negedge clk_sys);
         if (sck_w === 1'b1 && !prev)
            n++;
         prev = sck_w;
      end
      if (starts == s0) begin
         mismatches++;
         test_done;
      end
      chk("internal rises", 32'd32, 32'(n));
      host_u.sel(1'b1);
      strap <= 1'b0;
      host_u.tick(8);
      chk_mux;
   endtask : t_internal
   initial begin
      exp = MUX_RESET;
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      host_u.tick(3);
      chk_mux;
      chk("sdo_oe reset", 32'h0, 32'(pad.sdo_oe));
      t_pending;
      wait_ready;
      host_u.spin(3);
      foreach (tbl[i])
         t_frame(tbl[i], 32);
      t_frame(13'h17fe, 10);
      t_frame(13'h1402, 32);
      t_internal;
      test_done;
   end
endmodule : ascp_port_tb_top
